// [hw/ftc_pkg.sv]
package ftc_pkg;
   localparam int CLK_FREQ_MHZ = 10;
   localparam int CNT_W = 16;
   typedef logic [CNT_W-1:0] cnt_t;

   // least times round up to whole cycles, never below one
   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns * CLK_FREQ_MHZ + 999) / 1000;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int TXD_DOM_NS = 1000000;
   localparam int DET1_NS = 40000;
   localparam int DET2_NS = 400000;
   localparam int LOVER_NS = 40000;
   localparam int LGND_NS = 300000;
   localparam int REC_NS = 100000;
   localparam int WAKE_BUS_NS = 30000;
   localparam int SLEEP_HOLD_NS = 50000;
   localparam int TXD_DOM_CYC_DEF = ns_to_cyc(TXD_DOM_NS);
   localparam cnt_t DET1_CYC = cnt_t'(ns_to_cyc(DET1_NS));
   localparam cnt_t DET2_CYC = cnt_t'(ns_to_cyc(DET2_NS));
   localparam cnt_t LOVER_CYC = cnt_t'(ns_to_cyc(LOVER_NS));
   localparam cnt_t LGND_CYC = cnt_t'(ns_to_cyc(LGND_NS));
   localparam cnt_t REC_CYC = cnt_t'(ns_to_cyc(REC_NS));
   localparam cnt_t WAKE_BUS_CYC = cnt_t'(ns_to_cyc(WAKE_BUS_NS));
   localparam cnt_t SLEEP_HOLD_CYC = cnt_t'(ns_to_cyc(SLEEP_HOLD_NS));

   // modes coded as {low_power_select_n, mode_select_b}
   typedef enum logic [1:0] {
      MODE_SLEEP_STBY = 2'h0,
      MODE_GOTO_SLEEP = 2'h1,
      MODE_PWR_STBY = 2'h2,
      MODE_NORMAL = 2'h3
   } mode_e;

   typedef enum logic [2:0] {
      FS_NONE = 3'h0,
      FS_H_SINGLE = 3'h1,
      FS_H_FAIL = 3'h2,
      FS_L_FAIL = 3'h3,
      FS_L_GND = 3'h4
   } fail_e;

   typedef enum logic [1:0] {
      RX_DIFF = 2'h0,
      RX_HIGH = 2'h1,
      RX_LOW = 2'h2
   } rx_e;

   // synchroniser lanes
   localparam int SI_TX = 0;
   localparam int SI_LPS = 1;
   localparam int SI_MSB = 2;
   localparam int SI_ROUSE = 3;
   localparam int SI_VLOW = 4;
   localparam int SI_HOVER = 5;
   localparam int SI_LOVER = 6;
   localparam int SI_DIFF = 7;
   localparam int SI_HDOM = 8;
   localparam int SI_LDOM = 9;
   localparam int SI_OPEN = 10;
   localparam int SYNC_W = 11;
   localparam logic [SYNC_W-1:0] SYNC_RST = 11'h009;

   localparam logic [31:0] CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
   localparam int CTRL_TXTO_BIT = 0;
   localparam int CTRL_DET_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [hw/sync_if.sv]
`timescale 1ns/1ns
interface sync_if;
   import ftc_pkg::*;
   logic [SYNC_W-1:0] q;
   modport src(output q);
   modport dst(input q);
endinterface

// [hw/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync
   import ftc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [SYNC_W-1:0] raw,
   sync_if.src out
);
   logic [SYNC_W-1:0] meta_r;
   logic [SYNC_W-1:0] sync_r;

   // first stage feeds only the second stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= SYNC_RST;
         sync_r <= SYNC_RST;
      end else begin
         meta_r <= raw;
         sync_r <= meta_r;
      end
   end

   assign out.q = sync_r;
endmodule

// [hw/qual_timer.sv]
`timescale 1ns/1ns
module qual_timer
   import ftc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic level,
   input wire logic clr,
   input wire cnt_t limit,
   output logic done
);
   cnt_t cnt_r;

   // saturates so a long-held level stays qualified
   always_ff @(posedge aclk) begin
      if (!aresetn || clr || !level) begin
         cnt_r <= '0;
      end else if (cnt_r < limit) begin
         cnt_r <= cnt_r + cnt_t'(1);
      end
   end

   assign done = level && (cnt_r >= limit);
endmodule

// [hw/fault_tolerant_can_failure_manager.sv]
`timescale 1ns/1ns
// Summary of operation
// - transmitter disabled once transmit_in stays low beyond the dominant time-out
// - dominant time-out timer clears whenever transmit_in is sampled high
// - normal mode shows filtered differential receiver result on receive_out
// - failure detector fully active in normal mode, picks mode per failure
// - failures 1, 2, 5, 6a keep drivers, termination and differential reception
// - high line over its level: single-wire on high line after first time-out
// - still over after second time-out: low-line operation, high driver off, weak pull-down
// - high line to battery: high termination weak, high driver off, receive on low line
// - low line over threshold for a delay: high-line reception, low driver off, pull-up
// - failures 3, 3a, 6 recover after recessive level held for recovery period
// - failures 4, 7: dominant receive first, then low driver off, pull-up, single-wire
// - low line to ground: low termination weak, low driver off, receive on high line
// - failures 4, 7 removed: back to differential after recessive for set period
// - fault_wake_flag_n low whenever a wiring failure is detected
// - fault_wake_flag_n back high when the wiring failure has recovered
// - open wire flagged only between sender and receiver, so flag may toggle
// - standby and sleep: fault_wake_flag_n low means wake-up detected
// - power-on standby: fault_wake_flag_n low means battery power-on occurred
// - controller drives both select pins, device decodes them into its state
// - local_rouse_in is active low, both edges detected
// - regulator_control_out turns external regulator on at a wake-up
// - mode codes: 11 normal, 10 power-on standby, 00 standby/sleep, 01 goto-sleep
// - pending wake-up indications released on entering normal mode
// - supply below standby threshold forces both select inputs low internally
module fault_tolerant_can_failure_manager
   import ftc_pkg::*;
#(
   parameter int TXD_DOM_CYC = TXD_DOM_CYC_DEF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic transmit_in,
   input wire logic low_power_select_n,
   input wire logic mode_select_b,
   input wire logic local_rouse_in_n,
   input wire logic supply_low,
   input wire logic high_over_det,
   input wire logic low_over_det,
   input wire logic diff_dominant,
   input wire logic high_dominant,
   input wire logic low_dominant,
   input wire logic open_wire_det,
   output logic receive_out,
   output logic fault_wake_flag_n,
   output logic regulator_control_out,
   output logic transmit_dominant,
   output logic high_drv_en,
   output logic low_drv_en,
   output logic high_line_termination,
   output logic low_line_termination
);
   sync_if sif();
   logic tx_s, lps_s, msb_s, rouse_s, vlow_s, hov_s, lov_s, diff_s, hdom_s, ldom_s, open_s;
   mode_e mode_c, mode_r;
   fail_e fs_r, fs_nxt;
   rx_e rxm;
   logic [1:0] ctrl_r;
   logic normal, enter_normal, fs_chg;
   logic txd_to, tx_block_r;
   logic det_lvl, det_done, rec_lvl, rec_done;
   cnt_t det_lim;
   logic h_drv, l_drv, h_weak, l_weak, fail_any;
   logic rouse_d_r, bus_wake_lvl, bus_wake_done, sleep_done, sleep_d_r;
   logic wake_r, pwron_r, reg_on_r, wake_evt;
   logic aw_got_r, w_got_r, do_wr;
   logic [31:0] awaddr_r, wdata_r;
   logic [3:0] wstrb_r;

   pin_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw({open_wire_det, low_dominant, high_dominant, diff_dominant, low_over_det,
            high_over_det, supply_low, local_rouse_in_n, mode_select_b,
            low_power_select_n, transmit_in}),
      .out(sif)
   );

   assign tx_s = sif.q[SI_TX];
   assign lps_s = sif.q[SI_LPS];
   assign msb_s = sif.q[SI_MSB];
   assign rouse_s = sif.q[SI_ROUSE];
   assign vlow_s = sif.q[SI_VLOW];
   assign hov_s = sif.q[SI_HOVER];
   assign lov_s = sif.q[SI_LOVER];
   assign diff_s = sif.q[SI_DIFF];
   assign hdom_s = sif.q[SI_HDOM];
   assign ldom_s = sif.q[SI_LDOM];
   assign open_s = sif.q[SI_OPEN];

   // fail-safe: low supply forces both selects low
   // pin pair decoded into the mode
   assign mode_c = mode_e'({lps_s & ~vlow_s, msb_s & ~vlow_s});
   assign normal = (mode_c == MODE_NORMAL);
   assign enter_normal = normal && (mode_r != MODE_NORMAL);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= MODE_SLEEP_STBY;
      end else begin
         mode_r <= mode_c;
      end
   end

   qual_timer u_txto (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(~tx_s),
      .clr(1'h0),
      .limit(cnt_t'(TXD_DOM_CYC)),
      .done(txd_to)
   );

   // block lifts as soon as transmit_in reads high
   always_ff @(posedge aclk) begin
      if (!aresetn || tx_s) begin
         tx_block_r <= 1'h0;
      end else if (txd_to && ctrl_r[CTRL_TXTO_BIT]) begin
         tx_block_r <= 1'h1;
      end
   end

   // detection only runs in normal mode
   always_comb begin
      det_lvl = 1'h0;
      det_lim = DET1_CYC;
      rec_lvl = 1'h0;
      unique case (fs_r)
         FS_NONE: begin
            if (hov_s) begin
               det_lvl = normal;
               det_lim = DET1_CYC;
            end else if (lov_s) begin
               det_lvl = normal;
               det_lim = LOVER_CYC;
            end else if (diff_s) begin
               // long limit, so legal frames never trip it
               det_lvl = normal;
               det_lim = LGND_CYC;
            end
         end
         FS_H_SINGLE: begin
            det_lvl = normal && hov_s;
            det_lim = DET2_CYC;
            rec_lvl = ~hov_s;
         end
         FS_H_FAIL: rec_lvl = ~hov_s;
         FS_L_FAIL: rec_lvl = ~lov_s;
         FS_L_GND: rec_lvl = ~diff_s;
         default: rec_lvl = 1'h1;
      endcase
   end

   qual_timer u_det (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(det_lvl),
      .clr(fs_chg),
      .limit(det_lim),
      .done(det_done)
   );

   qual_timer u_rec (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(rec_lvl),
      .clr(fs_chg),
      .limit(REC_CYC),
      .done(rec_done)
   );

   always_comb begin
      fs_nxt = fs_r;
      unique case (fs_r)
         FS_NONE: begin
            if (det_done && hov_s) begin
               fs_nxt = FS_H_SINGLE;
            end else if (det_done && lov_s) begin
               fs_nxt = FS_L_FAIL;
            // continuous dominant: short to ground or lines shorted
            end else if (det_done && diff_s) begin
               fs_nxt = FS_L_GND;
            end
         end
         FS_H_SINGLE: begin
            if (det_done) begin
               fs_nxt = FS_H_FAIL;
            end else if (rec_done) begin
               fs_nxt = FS_NONE;
            end
         end
         FS_H_FAIL, FS_L_FAIL, FS_L_GND: begin
            if (rec_done) begin
               fs_nxt = FS_NONE;
            end
         end
         default: fs_nxt = FS_NONE;
      endcase
   end

   assign fs_chg = (fs_nxt != fs_r);

   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_r[CTRL_DET_BIT]) begin
         fs_r <= FS_NONE;
      end else begin
         fs_r <= fs_nxt;
      end
   end

   // failures 1, 2, 5, 6a never leave FS_NONE: all on, differential
   always_comb begin
      h_drv = 1'h1;
      l_drv = 1'h1;
      h_weak = 1'h0;
      l_weak = 1'h0;
      rxm = RX_DIFF;
      unique case (fs_r)
         FS_NONE: rxm = RX_DIFF;
         FS_H_SINGLE: rxm = RX_HIGH;
         // high line off, weak pull-down, receive on low line
         FS_H_FAIL: begin
            h_drv = 1'h0;
            h_weak = 1'h1;
            rxm = RX_LOW;
         end
         // low line off, weak pull-up, receive on high line
         FS_L_FAIL, FS_L_GND: begin
            l_drv = 1'h0;
            l_weak = 1'h1;
            rxm = RX_HIGH;
         end
         default: rxm = RX_DIFF;
      endcase
   end

   // open wire only seen when the break splits sender and receiver
   assign fail_any = (fs_r != FS_NONE) || open_s;

   // remote wake needs bus dominance held, not a glitch
   assign bus_wake_lvl = !normal && (diff_s || hdom_s || ldom_s);

   qual_timer u_bus_wake (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(bus_wake_lvl),
      .clr(1'h0),
      .limit(WAKE_BUS_CYC),
      .done(bus_wake_done)
   );

   qual_timer u_sleep (
      .aclk(aclk),
      .aresetn(aresetn),
      .level(mode_c == MODE_GOTO_SLEEP),
      .clr(1'h0),
      .limit(SLEEP_HOLD_CYC),
      .done(sleep_done)
   );

   // either edge of the rouse input
   assign wake_evt = !normal && ((rouse_s != rouse_d_r) || bus_wake_done);

   // wake and power-on flags release on entering normal; a set wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rouse_d_r <= 1'h1;
         wake_r <= 1'h0;
         pwron_r <= 1'h1;
      end else begin
         rouse_d_r <= rouse_s;
         if (enter_normal) begin
            wake_r <= 1'h0;
            pwron_r <= 1'h0;
         end
         if (wake_evt) begin
            wake_r <= 1'h1;
         end
      end
   end

   // regulator back on at a wake or select_n high
   // off only as the goto-sleep hold completes, so a later wake is not undone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reg_on_r <= 1'h1;
         sleep_d_r <= 1'h0;
      end else begin
         sleep_d_r <= sleep_done;
         if (wake_evt || (lps_s && !vlow_s)) begin
            reg_on_r <= 1'h1;
         end else if (sleep_done && !sleep_d_r) begin
            reg_on_r <= 1'h0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         receive_out <= 1'h1;
         fault_wake_flag_n <= 1'h1;
         regulator_control_out <= 1'h1;
         transmit_dominant <= 1'h0;
         high_drv_en <= 1'h0;
         low_drv_en <= 1'h0;
         high_line_termination <= 1'h0;
         low_line_termination <= 1'h0;
      end else begin
         regulator_control_out <= reg_on_r;
         transmit_dominant <= normal && !tx_s && !tx_block_r;
         high_drv_en <= normal && h_drv;
         low_drv_en <= normal && l_drv;
         high_line_termination <= h_weak;
         low_line_termination <= l_weak;
         if (normal) begin
            unique case (rxm)
               RX_DIFF: receive_out <= ~diff_s;
               RX_HIGH: receive_out <= ~hdom_s;
               RX_LOW: receive_out <= ~ldom_s;
               default: receive_out <= ~diff_s;
            endcase
            fault_wake_flag_n <= ~fail_any;
         end else begin
            receive_out <= ~wake_r;
            fault_wake_flag_n <= (mode_c == MODE_PWR_STBY) ? ~pwron_r : ~wake_r;
         end
      end
   end

   // register slave: write address and data taken in either order
   assign awready = !aw_got_r && !bvalid;
   assign wready = !w_got_r && !bvalid;
   assign do_wr = aw_got_r && w_got_r && !bvalid;
   assign arready = !rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_r <= 1'h0;
         w_got_r <= 1'h0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         bvalid <= 1'h0;
         bresp <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_got_r <= 1'h1;
            awaddr_r <= awaddr;
         end
         if (wvalid && wready) begin
            w_got_r <= 1'h1;
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
         if (do_wr) begin
            aw_got_r <= 1'h0;
            w_got_r <= 1'h0;
            bvalid <= 1'h1;
            bresp <= (awaddr_r == CTRL_OFS || awaddr_r == STATUS_OFS) ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'h0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= CTRL_RST;
      end else if (do_wr && awaddr_r == CTRL_OFS && wstrb_r[0]) begin
         ctrl_r <= wdata_r[1:0];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'h0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'h1;
         rresp <= RESP_OKAY;
         if (araddr == CTRL_OFS) begin
            rdata <= {30'h0, ctrl_r};
         end else if (araddr == STATUS_OFS) begin
            rdata <= {23'h0, reg_on_r, pwron_r, wake_r, tx_block_r, mode_r, fs_r};
         end else begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'h0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence h_step2_s;
      fs_r == FS_H_SINGLE && det_done;
   endsequence
   sequence h_off_s;
      fs_r == FS_H_FAIL ##1 (!high_drv_en && high_line_termination);
   endsequence

   txd_block_a: assert property (txd_to && ctrl_r[0] && !tx_s |=> ##1 !transmit_dominant)
      else $error("transmitter not blocked after dominant time-out");
   txd_clear_a: assert property (tx_s |=> !tx_block_r)
      else $error("dominant block not cleared by high transmit_in");
   rx_diff_a: assert property (normal && fs_r == FS_NONE |=> receive_out == !$past(diff_s))
      else $error("receive_out not following differential receiver");
   high_step1_a: assert property (fs_r == FS_NONE && det_done && hov_s |=> fs_r == FS_H_SINGLE)
      else $error("no single-wire switch after first time-out");
   high_step2_a: assert property (h_step2_s |=> h_off_s)
      else $error("high driver not off after second time-out");
   low_over_a: assert property (fs_r == FS_L_FAIL && normal |=> !low_drv_en && low_line_termination)
      else $error("low line failure settings wrong");
   recover_a: assert property (fs_r != FS_NONE && fs_r != FS_H_SINGLE && rec_done |=> fs_r == FS_NONE)
      else $error("no recovery after recessive period");
   fail_flag_a: assert property (normal && fs_r != FS_NONE |=> !fault_wake_flag_n)
      else $error("fault flag not low on failure");
   wake_release_a: assert property (enter_normal |=> !pwron_r && !wake_r)
      else $error("wake flags not released on normal entry");
   supply_low_a: assert property (vlow_s |=> !high_drv_en && !low_drv_en && !transmit_dominant)
      else $error("bus outputs active under low supply");
endmodule

// [bench/ctl_model.sv]
`timescale 1ns/1ns
module ctl_model
   import ftc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire mode_e mode_req,
   input wire logic tx_req,
   output logic transmit_in,
   output logic low_power_select_n,
   output logic mode_select_b
);
   // pins move only just after an edge; recessive while in reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         transmit_in <= 1'h1;
      end else begin
         transmit_in <= !tx_req;
      end
   end
   always_ff @(posedge aclk) begin
      {low_power_select_n, mode_select_b} <= mode_req;
   end
endmodule

// [bench/fault_tolerant_can_failure_manager_bench.sv]
`timescale 1ns/1ns
module fault_tolerant_can_failure_manager_bench;
   import ftc_pkg::*;
   localparam int TXTO = 20;
   logic aclk;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   mode_e mode_req = MODE_PWR_STBY;
   logic tx_req = 1'h0, rouse_n = 1'h1, sup_low = 1'h0;
   logic hov = 1'h0, lov = 1'h0, ddom = 1'h0, open_w = 1'h0, hdom = 1'h0, ldom = 1'h0;
   logic transmit_in, lps_n, msb, rxo, flag_n, reg_on, tx_dom, hdrv, ldrv, hterm, lterm;
   int n_fail = 0;
   int num_checks = 0;
   int len;
   logic [31:0] rnd;

   ctl_model u_ctl_model (.aclk(aclk), .aresetn(aresetn), .mode_req(mode_req),
      .tx_req(tx_req), .transmit_in(transmit_in), .low_power_select_n(lps_n),
      .mode_select_b(msb));

   fault_tolerant_can_failure_manager #(.TXD_DOM_CYC(TXTO)) u_fault_tolerant_can_failure_manager (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .transmit_in(transmit_in), .low_power_select_n(lps_n), .mode_select_b(msb),
      .local_rouse_in_n(rouse_n), .supply_low(sup_low), .high_over_det(hov),
      .low_over_det(lov), .diff_dominant(ddom), .high_dominant(hdom), .low_dominant(ldom),
      .open_wire_det(open_w), .receive_out(rxo), .fault_wake_flag_n(flag_n),
      .regulator_control_out(reg_on), .transmit_dominant(tx_dom), .high_drv_en(hdrv),
      .low_drv_en(ldrv), .high_line_termination(hterm), .low_line_termination(lterm));

   initial begin
      aclk = 1'h0;
      forever #50 aclk = ~aclk;
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic hang();
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, 1'h0, 1'h1);
      print_verdict();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // bounded waits: a slave that never answers ends the run
   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
      int i;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      rs = bresp;
      if (i == 50) hang();
   endtask

   task automatic axi_rd(input logic [31:0] a);
      int i;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      rd = rdata;
      rs = rresp;
      if (i == 50) hang();
   endtask

   // expected {hdrv, ldrv, hterm, lterm} for each failure state
   function automatic logic [3:0] exp_pins(input int st);
      case (st)
         2: return 4'h6;
         3, 4: return 4'h9;
         default: return 4'hc;
      endcase
   endfunction

   task automatic chk_state(input int st);
      logic b;
      axi_rd(STATUS_OFS);
      check(rd[2:0], st);
      check({hdrv, ldrv, hterm, lterm}, exp_pins(st));
      check(flag_n, st == 0);
      // one single-wire receiver dominant, the other recessive
      b = $urandom;
      hdom <= b;
      ldom <= !b;
      cyc(4);
      check(rxo, (st == 0) ? 1'h1 : (st == 2) ? b : !b);
      hdom <= 1'h0;
      ldom <= 1'h0;
   endtask

   initial begin
      void'($urandom(32'h0395));
      cyc(4);
      check({rxo, flag_n, reg_on, tx_dom, hdrv, ldrv, hterm, lterm}, 8'he0);
      aresetn <= 1'h1;
      cyc(6);
      check(flag_n, 0);
      axi_rd(CTRL_OFS);
      check(rs, RESP_OKAY);
      check(rd, {30'h0, CTRL_RST});
      axi_rd(32'h0000_0010);
      check(rs, RESP_SLVERR);
      check(rd, 32'h0);
      rnd = $urandom;
      axi_wr(CTRL_OFS, rnd);
      check(rs, RESP_OKAY);
      axi_rd(CTRL_OFS);
      check(rd, {30'h0, rnd[1:0]});
      axi_wr(CTRL_OFS, 32'h3);
      $display("test registers done");
      mode_req <= MODE_NORMAL;
      cyc(8);
      check(flag_n, 1);
      ddom <= 1'h1;
      cyc(6);
      check(rxo, 0);
      ddom <= 1'h0;
      cyc(6);
      check(rxo, 1);
      open_w <= 1'h1;
      cyc(6);
      check(flag_n, 0);
      open_w <= 1'h0;
      cyc(6);
      check(flag_n, 1);
      $display("test receive done");
      tx_req <= 1'h1;
      cyc(6);
      check(tx_dom, 1);
      cyc(TXTO + 4);
      check(tx_dom, 0);
      tx_req <= 1'h0;
      cyc(2);
      repeat (4) begin
         len = 8 + $urandom % 8;
         tx_req <= 1'h1;
         cyc(len);
         check(tx_dom, 1);
         tx_req <= 1'h0;
         cyc(1);
      end
      cyc(4);
      $display("test dominant timeout done");
      hov <= 1'h1;
      cyc(DET1_CYC - 5);
      check(flag_n, 1);
      cyc(13);
      chk_state(1);
      cyc(DET2_CYC + 8);
      chk_state(2);
      hov <= 1'h0;
      cyc(REC_CYC + 8);
      chk_state(0);
      lov <= 1'h1;
      cyc(LOVER_CYC + 8);
      chk_state(3);
      lov <= 1'h0;
      cyc(REC_CYC + 8);
      chk_state(0);
      ddom <= 1'h1;
      cyc(LGND_CYC + 8);
      chk_state(4);
      ddom <= 1'h0;
      cyc(REC_CYC + 8);
      chk_state(0);
      $display("test failures done");
      sup_low <= 1'h1;
      cyc(6);
      // pins go to sleep before the supply returns, so no normal glimpse
      mode_req <= MODE_SLEEP_STBY;
      axi_rd(STATUS_OFS);
      check(rd[4:3], 0);
      sup_low <= 1'h0;
      cyc(6);
      check({flag_n, reg_on}, 2'h3);
      rouse_n <= 1'h0;
      cyc(6);
      check({flag_n, rxo, reg_on}, 3'h1);
      mode_req <= MODE_NORMAL;
      cyc(6);
      check(flag_n, 1);
      mode_req <= MODE_GOTO_SLEEP;
      cyc(SLEEP_HOLD_CYC + 8);
      check(reg_on, 0);
      rouse_n <= 1'h1;
      cyc(6);
      check({flag_n, reg_on}, 2'h1);
      $display("test low power done");
      print_verdict();
   end
endmodule
